// ==== deh_cmd_handler.v ====
// Contract
// - T or no modifier selects TCP.
// - P stores UDP addressing, sends nothing.
// - Stored selector uses a directory address.
// - Stored index ranges zero to nine.
// - Semicolon keeps command mode after setup.
// - Semicolon dial finishes with OK.
// - Broken or aborted dial reports NO CARRIER.
// - TCP remote hangup, lost link: NO CARRIER.
// - Terminal-ready drop with option: NO CARRIER.
// - Refused: BUSY, else NO CARRIER.
// - Timeout: NO ANSWER, else NO CARRIER.
// - Unregistered: NO DIALTONE, else NO CARRIER.
// - Network reject: ERROR, store reason code.
// - PIN pending: NOT ENABLED.
// - Command echo off at 0, on at 1.
// - Online echo on at 0, off at 1.
// - Hangup 0 drains, then terminates.
// - Hangup 1 does nothing, returns OK.
// - Hangup 2 discards and terminates now.
// - Hangup 3 also deregisters.
// - A new hangup command may change a running hangup.
// - Missing port defaults to 23.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "deh_consts.vh"

module deh_cmd_handler #(
	parameter TICK_CYCLES = `DEH_CLK_HZ * `DEH_S7_UNIT_S // Cycles per second.
) (
	input  wire        mclk_in,           // System clock.
	input  wire        resetn_in,         // Asynchronous reset, active low.
	input  wire [7:0]  s_axi_awaddr_in,   // Write address.
	input  wire        s_axi_awvalid_in,  // Write address valid.
	output reg         s_axi_awready_out, // Write address ready.
	input  wire [31:0] s_axi_wdata_in,    // Write data.
	input  wire [3:0]  s_axi_wstrb_in,    // Write byte strobes.
	input  wire        s_axi_wvalid_in,   // Write data valid.
	output reg         s_axi_wready_out,  // Write data ready.
	output reg  [1:0]  s_axi_bresp_out,   // Write response.
	output reg         s_axi_bvalid_out,  // Write response valid.
	input  wire        s_axi_bready_in,   // Write response ready.
	input  wire [7:0]  s_axi_araddr_in,   // Read address.
	input  wire        s_axi_arvalid_in,  // Read address valid.
	output reg         s_axi_arready_out, // Read address ready.
	output reg  [31:0] s_axi_rdata_out,   // Read data.
	output reg  [1:0]  s_axi_rresp_out,   // Read response.
	output reg         s_axi_rvalid_out,  // Read data valid.
	input  wire        s_axi_rready_in,   // Read data ready.
	input  wire        dtr_in,            // Terminal-ready pin, high active.
	input  wire        host_input_in,     // Host character arrived pulse.
	input  wire        registered_in,     // Modem registered level.
	input  wire        pin_required_in,   // PIN entry pending level.
	input  wire        net_accept_in,     // Setup accepted pulse.
	input  wire        net_refuse_in,     // Remote refused pulse.
	input  wire        net_reject_in,     // Network rejected pulse.
	input  wire [15:0] net_reason_in,     // Reject reason with reject.
	input  wire        net_remote_hup_in, // Remote hung up pulse.
	input  wire        link_lost_in,      // Radio link lost level.
	input  wire        tx_attempt_in,     // Local send attempt pulse.
	input  wire        pend_empty_in,     // Pending buffer empty level.
	output reg         net_setup_out,     // Start TCP setup pulse.
	output reg         net_udp_out,       // Session is UDP level.
	output reg  [31:0] net_ip_out,        // Destination address.
	output reg  [15:0] net_port_out,      // Destination port.
	output reg         net_flush_out,     // Send pending data pulse.
	output reg         net_discard_out,   // Drop pending data pulse.
	output reg         net_term_out,      // Close connection pulse.
	output reg         net_dereg_out,     // Deregister pulse.
	output reg         online_out,        // Online mode level.
	output reg         echo_cmd_out,      // Command mode echo level.
	output reg         echo_online_out    // Online local echo level.
);

	////////////////////////////////////////////////////////////////////
	// One-hot states of the connection sequencer.
	localparam [3:0] ST_IDLE  = 4'h1; // No connection.
	localparam [3:0] ST_WAIT  = 4'h2; // Setup under way.
	localparam [3:0] ST_CONN  = 4'h4; // Connection exists.
	localparam [3:0] ST_DRAIN = 4'h8; // Draining before close.

	// Non-extended results fold into NO CARRIER.
	function [3:0] deh_map;
		input       ext;
		input [3:0] code;
		begin
			deh_map = ext ? code : `DEH_RC_NOCAR;
		end
	endfunction

	// Merges a write word into a register under byte strobes.
	function [31:0] deh_merge;
		input [31:0] old;
		input [31:0] val;
		input [3:0]  strb;
		integer      k;
		begin
			deh_merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (strb[k])
					deh_merge[k*8 +: 8] = val[k*8 +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	reg         rst_s1_q;    // Reset release stage one.
	reg         rst_s2_q;    // Reset release stage two.
	wire        rst_n;       // Synchronised reset.
	reg         dtr_s1_q;    // Terminal-ready sync stage one.
	reg         dtr_s2_q;    // Terminal-ready sync stage two.
	reg         dtr_s3_q;    // Previous synced terminal-ready.
	reg  [7:0]  awa_q;       // Latched write address.
	reg  [31:0] wd_q;        // Latched write data.
	reg  [3:0]  ws_q;        // Latched write strobes.
	reg         aw_ok_q;     // Write address held.
	reg         w_ok_q;      // Write data held.
	reg  [31:0] cmd_q;       // Last command word.
	reg         cmd_go_q;    // New command pulse.
	reg  [31:0] cfg_q;       // Configuration word.
	reg  [31:0] ip_q;        // Explicit destination address.
	reg  [31:0] dir_q [0:9]; // Stored destination addresses.
	reg         clr_q;       // Result clear pulse.
	reg  [3:0]  state_q;     // Sequencer state.
	reg  [3:0]  res_q;       // Last result code.
	reg         res_vld_q;   // Result waiting for software.
	reg         semi_q;      // Dial asked to stay in command mode.
	reg  [15:0] rej_q;       // Reject reason, high and low byte.
	reg  [31:0] tick_q;      // Cycle count within a second.
	reg  [7:0]  sec_q;       // Seconds waited for an answer.
	reg  [31:0] rd_d;        // Read data of the current address.
	reg         rd_ok_d;     // Read address is mapped.
	wire        dir_w;       // Write address hits the directory.
	wire        dir_r;       // Read address hits the directory.
	wire [3:0]  op_arg;      // Argument of the command.
	wire        dtr_fall;    // Terminal-ready went inactive.
	integer     i;           // Directory reset index.

	assign rst_n    = rst_s2_q;
	assign dtr_fall = dtr_s3_q & ~dtr_s2_q;
	assign op_arg   = cmd_q[`DEH_F_ARG];
	assign dir_w    = (awa_q[7:6] == `DEH_A_DIR) &&
		(awa_q[5:2] <= `DEH_DIR_LAST);
	assign dir_r    = (s_axi_araddr_in[7:6] == `DEH_A_DIR) &&
		(s_axi_araddr_in[5:2] <= `DEH_DIR_LAST);

	////////////////////////////////////////////////////////////////////
	// Reset release and terminal-ready pin synchronisers.
	always @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// The third stage feeds the edge detector only.
	always @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dtr_s1_q <= 1'b0;
			dtr_s2_q <= 1'b0;
			dtr_s3_q <= 1'b0;
		end
		else
		begin
			dtr_s1_q <= dtr_in;
			dtr_s2_q <= dtr_s1_q;
			dtr_s3_q <= dtr_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write channels: address and data are taken in either order.
	always @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `DEH_RESP_OK;
			aw_ok_q  <= 1'b0;
			w_ok_q   <= 1'b0;
			awa_q    <= 8'h00;
			wd_q     <= 32'h00000000;
			ws_q     <= 4'h0;
			cmd_q    <= 32'h00000000;
			cmd_go_q <= 1'b0;
			clr_q    <= 1'b0;
			cfg_q    <= `DEH_CFG_RST;
			ip_q     <= 32'h00000000;
			for (i = 0; i < 10; i = i + 1)
				dir_q[i] <= 32'h00000000;
		end
		else
		begin
			cmd_go_q <= 1'b0;
			clr_q    <= 1'b0;
			// Address phase.
			if (s_axi_awready_out && s_axi_awvalid_in)
			begin
				awa_q             <= s_axi_awaddr_in;
				aw_ok_q           <= 1'b1;
				s_axi_awready_out <= 1'b0;
			end
			else if (!aw_ok_q && !s_axi_bvalid_out)
				s_axi_awready_out <= 1'b1;
			// Data phase.
			if (s_axi_wready_out && s_axi_wvalid_in)
			begin
				wd_q             <= s_axi_wdata_in;
				ws_q             <= s_axi_wstrb_in;
				w_ok_q           <= 1'b1;
				s_axi_wready_out <= 1'b0;
			end
			else if (!w_ok_q && !s_axi_bvalid_out)
				s_axi_wready_out <= 1'b1;
			// Both held: perform the write and answer.
			if (aw_ok_q && w_ok_q)
			begin
				aw_ok_q          <= 1'b0;
				w_ok_q           <= 1'b0;
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= `DEH_RESP_OK;
				if (dir_w)
					dir_q[awa_q[5:2]] <= deh_merge(dir_q[awa_q[5:2]],
						wd_q, ws_q);
				else
					case (awa_q)
					`DEH_A_CTRL:
					begin
						// A command write also interrupts setup; a hangup command also replaces a draining hangup.
						cmd_q    <= deh_merge(cmd_q, wd_q, ws_q);
						cmd_go_q <= 1'b1;
					end
					`DEH_A_CFG:  cfg_q <= deh_merge(cfg_q, wd_q, ws_q);
					`DEH_A_IP:   ip_q  <= deh_merge(ip_q, wd_q, ws_q);
					`DEH_A_STAT: clr_q <= 1'b1;
					`DEH_A_DEST, `DEH_A_REJ: ;
					default:     s_axi_bresp_out <= `DEH_RESP_ERR;
					endcase
			end
			else if (s_axi_bvalid_out && s_axi_bready_in)
				s_axi_bvalid_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data selection for the address on the read channel.
	always @*
	begin
		rd_d    = 32'h00000000;
		rd_ok_d = 1'b1;
		if (dir_r)
			rd_d = dir_q[s_axi_araddr_in[5:2]];
		else
			case (s_axi_araddr_in)
			`DEH_A_CTRL: rd_d = cmd_q;
			`DEH_A_CFG:  rd_d = cfg_q;
			`DEH_A_IP:   rd_d = ip_q;
			`DEH_A_STAT: rd_d = {20'h00000, registered_in, net_udp_out,
				echo_online_out, echo_cmd_out, state_q[2] | state_q[3],
				online_out, state_q[1] | state_q[3], res_vld_q, res_q};
			`DEH_A_DEST: rd_d = {net_port_out, 16'h0000};
			`DEH_A_REJ:  rd_d = {16'h0000, rej_q};
			default:     rd_ok_d = 1'b0;
			endcase
	end

	// Read channel: one read at a time, data held until taken.
	always @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h00000000;
			s_axi_rresp_out   <= `DEH_RESP_OK;
		end
		else if (s_axi_arready_out && s_axi_arvalid_in)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rdata_out   <= rd_d;
			s_axi_rresp_out   <= rd_ok_d ? `DEH_RESP_OK : `DEH_RESP_ERR;
		end
		else if (s_axi_rvalid_out)
		begin
			if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
		else
			s_axi_arready_out <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// Connection sequencer, echo settings and result reporting.
	// A result posted in the cycle of a clear survives: set wins.
	always @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q         <= ST_IDLE;
			res_q           <= `DEH_RC_OK;
			res_vld_q       <= 1'b0;
			semi_q          <= 1'b0;
			rej_q           <= 16'h0000;
			tick_q          <= 32'h00000000;
			sec_q           <= 8'h00;
			net_setup_out   <= 1'b0;
			net_udp_out     <= 1'b0;
			net_ip_out      <= 32'h00000000;
			net_port_out    <= `DEH_DEF_PORT;
			net_flush_out   <= 1'b0;
			net_discard_out <= 1'b0;
			net_term_out    <= 1'b0;
			net_dereg_out   <= 1'b0;
			online_out      <= 1'b0;
			echo_cmd_out    <= 1'b1;
			echo_online_out <= 1'b0;
		end
		else
		begin
			net_setup_out   <= 1'b0;
			net_flush_out   <= 1'b0;
			net_discard_out <= 1'b0;
			net_term_out    <= 1'b0;
			net_dereg_out   <= 1'b0;
			if (clr_q)
				res_vld_q <= 1'b0;
			// Echo settings are taken in every state but setup.
			if (cmd_go_q && !state_q[1] &&
				(cmd_q[`DEH_F_OP] == `DEH_OP_ECHO_C ||
				cmd_q[`DEH_F_OP] == `DEH_OP_ECHO_O))
			begin
				res_vld_q <= 1'b1;
				if (op_arg > `DEH_ARG_ON)
					res_q <= `DEH_RC_ERR;
				else
				begin
					res_q <= `DEH_RC_OK;
					if (cmd_q[`DEH_F_OP] == `DEH_OP_ECHO_C)
						echo_cmd_out <= op_arg[0];
					else
						echo_online_out <= ~op_arg[0];
				end
			end
			case (state_q)
			ST_IDLE:
				if (cmd_go_q && cmd_q[`DEH_F_OP] == `DEH_OP_DIAL)
				begin
					res_vld_q <= 1'b1;
					if (pin_required_in)
						res_q <= `DEH_RC_NOTEN;
					else if ((cmd_q[`DEH_F_STORED] &&
						cmd_q[`DEH_F_IDX] > `DEH_DIR_LAST) ||
						cmd_q[`DEH_F_PROTO] > `DEH_PR_UDP)
						res_q <= `DEH_RC_ERR;
					else if (!registered_in)
						res_q <= deh_map(cfg_q[`DEH_F_EXT],
							`DEH_RC_NODIAL);
					else
					begin
						// Address from the directory or the explicit one.
						net_ip_out <= cmd_q[`DEH_F_STORED] ?
							dir_q[cmd_q[`DEH_F_IDX]] : ip_q;
						net_port_out <= (cmd_q[`DEH_F_PORT] == 16'h0000) ?
							`DEH_DEF_PORT : cmd_q[`DEH_F_PORT];
						semi_q <= cmd_q[`DEH_F_SEMI];
						net_udp_out <= (cmd_q[`DEH_F_PROTO] ==
							`DEH_PR_UDP);
						if (cmd_q[`DEH_F_PROTO] == `DEH_PR_UDP)
						begin
							// Only the addressing is kept; no traffic yet.
							state_q    <= ST_CONN;
							online_out <= ~cmd_q[`DEH_F_SEMI];
							res_q <= cmd_q[`DEH_F_SEMI] ?
								`DEH_RC_OK : `DEH_RC_CONN;
						end
						else
						begin
							res_vld_q     <= 1'b0;
							net_setup_out <= 1'b1;
							state_q       <= ST_WAIT;
							tick_q        <= 32'h00000000;
							sec_q         <= 8'h00;
						end
					end
				end
				else if (cmd_go_q && cmd_q[`DEH_F_OP] == `DEH_OP_HANG)
				begin
					res_vld_q <= 1'b1;
					if (op_arg > `DEH_ARG_HMAX)
						res_q <= `DEH_RC_ERR;
					else
					begin
						res_q         <= `DEH_RC_OK;
						net_dereg_out <= (op_arg == `DEH_ARG_HMAX);
					end
				end
			ST_WAIT:
			begin
				// Seconds counted against the configured answer timeout.
				if (tick_q == TICK_CYCLES - 1)
				begin
					tick_q <= 32'h00000000;
					sec_q  <= sec_q + 8'h01;
				end
				else
					tick_q <= tick_q + 32'h00000001;
				if (cmd_go_q || host_input_in)
				begin
					state_q      <= ST_IDLE;
					net_term_out <= 1'b1;
					res_q        <= `DEH_RC_NOCAR;
					res_vld_q    <= 1'b1;
				end
				else if (net_accept_in)
				begin
					state_q    <= ST_CONN;
					online_out <= ~semi_q;
					res_q      <= semi_q ? `DEH_RC_OK : `DEH_RC_CONN;
					res_vld_q  <= 1'b1;
				end
				else if (net_reject_in)
				begin
					state_q   <= ST_IDLE;
					rej_q     <= net_reason_in;
					res_q     <= `DEH_RC_ERR;
					res_vld_q <= 1'b1;
				end
				else if (net_refuse_in)
				begin
					state_q   <= ST_IDLE;
					res_q     <= deh_map(cfg_q[`DEH_F_EXT],
						`DEH_RC_BUSY);
					res_vld_q <= 1'b1;
				end
				else if (sec_q >= cfg_q[`DEH_F_S7])
				begin
					state_q      <= ST_IDLE;
					net_term_out <= 1'b1;
					res_q        <= deh_map(cfg_q[`DEH_F_EXT],
						`DEH_RC_NOANS);
					res_vld_q    <= 1'b1;
				end
			end
			ST_CONN, ST_DRAIN:
				if (dtr_fall && cfg_q[`DEH_F_DTROPT])
				begin
					// Drop and hang up discards like a variant 2 hangup.
					state_q         <= ST_IDLE;
					online_out      <= 1'b0;
					net_discard_out <= 1'b1;
					net_term_out    <= 1'b1;
					res_q           <= `DEH_RC_NOCAR;
					res_vld_q       <= 1'b1;
				end
				else if (!net_udp_out && (net_remote_hup_in ||
					(tx_attempt_in && link_lost_in)))
				begin
					state_q    <= ST_IDLE;
					online_out <= 1'b0;
					res_q      <= `DEH_RC_NOCAR;
					res_vld_q  <= 1'b1;
				end
				else if (cmd_go_q && cmd_q[`DEH_F_OP] == `DEH_OP_HANG)
				begin
					// A later hangup replaces one still draining.
					res_vld_q <= 1'b1;
					if (op_arg > `DEH_ARG_HMAX)
						res_q <= `DEH_RC_ERR;
					else if (op_arg == 4'h0)
					begin
						res_vld_q     <= 1'b0;
						net_flush_out <= 1'b1;
						state_q       <= ST_DRAIN;
					end
					else if (op_arg == `DEH_ARG_ON)
					begin
						res_q   <= `DEH_RC_OK;
						state_q <= ST_CONN;
					end
					else
					begin
						state_q         <= ST_IDLE;
						online_out      <= 1'b0;
						net_discard_out <= 1'b1;
						net_term_out    <= 1'b1;
						net_dereg_out   <= (op_arg == `DEH_ARG_HMAX);
						res_q           <= `DEH_RC_OK;
					end
				end
				else if (cmd_go_q && cmd_q[`DEH_F_OP] == `DEH_OP_DIAL)
				begin
					res_q     <= `DEH_RC_ERR;
					res_vld_q <= 1'b1;
				end
				else if (state_q[3] && pend_empty_in)
				begin
					// Everything pending has gone; now close.
					state_q      <= ST_IDLE;
					online_out   <= 1'b0;
					net_term_out <= 1'b1;
					res_q        <= `DEH_RC_OK;
					res_vld_q    <= 1'b1;
				end
			default:
				state_q <= ST_IDLE;
			endcase
		end
	end

endmodule // deh_cmd_handler

// ==== deh_consts.vh ====
`ifndef DEH_CONSTS_VH
`define DEH_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define DEH_A_CTRL     8'h00
`define DEH_A_CFG      8'h04
`define DEH_A_STAT     8'h08
`define DEH_A_IP       8'h0C
`define DEH_A_DEST     8'h10
`define DEH_A_REJ      8'h14
`define DEH_A_DIR      2'h1
`define DEH_DIR_LAST   4'h9

// Command word fields.
`define DEH_F_OP       2:0
`define DEH_F_ARG      7:4
`define DEH_F_PROTO    9:8
`define DEH_F_STORED   10
`define DEH_F_IDX      14:11
`define DEH_F_SEMI     15
`define DEH_F_PORT     31:16

// Command opcodes.
`define DEH_OP_DIAL    3'h1
`define DEH_OP_ECHO_C  3'h2
`define DEH_OP_ECHO_O  3'h3
`define DEH_OP_HANG    3'h4

// Protocol modifier codes.
`define DEH_PR_NONE    2'h0
`define DEH_PR_TCP     2'h1
`define DEH_PR_UDP     2'h2

// Configuration fields and reset value.
`define DEH_F_EXT      0
`define DEH_F_DTROPT   1
`define DEH_F_S7       15:8
`define DEH_CFG_RST    32'h00001401

// Default destination port and argument limits.
`define DEH_DEF_PORT   16'h0017
`define DEH_ARG_ON     4'h1
`define DEH_ARG_HMAX   4'h3

// Result codes in terse numbering.
`define DEH_RC_OK      4'h0
`define DEH_RC_CONN    4'h1
`define DEH_RC_NOCAR   4'h3
`define DEH_RC_ERR     4'h4
`define DEH_RC_NODIAL  4'h6
`define DEH_RC_BUSY    4'h7
`define DEH_RC_NOANS   4'h8
`define DEH_RC_NOTEN   4'hA

// AXI response codes.
`define DEH_RESP_OK    2'h0
`define DEH_RESP_ERR   2'h2

// Clock rate and timeout unit.
`define DEH_CLK_HZ     40000000
`define DEH_S7_UNIT_S  1

`endif

// ==== deh_cmd_chk_assertions.sv ====
`timescale 1ns/1ps
// Watches the bus handshake and the network-side pulses of the handler.
module deh_cmd_chk (
	input wire logic        mclk_in,           // Clock.
	input wire logic        resetn_in,         // Reset, active low.
	input wire logic        s_axi_awvalid_in,  // Write address valid.
	input wire logic        s_axi_awready_out, // Write address ready.
	input wire logic        s_axi_wvalid_in,   // Write data valid.
	input wire logic        s_axi_wready_out,  // Write data ready.
	input wire logic        s_axi_bvalid_out,  // Write response valid.
	input wire logic        s_axi_bready_in,   // Write response ready.
	input wire logic [1:0]  s_axi_bresp_out,   // Write response.
	input wire logic        s_axi_rvalid_out,  // Read valid.
	input wire logic        s_axi_rready_in,   // Read ready.
	input wire logic [31:0] s_axi_rdata_out,   // Read data.
	input wire logic        net_setup_out,     // Setup pulse.
	input wire logic        net_udp_out,       // UDP session.
	input wire logic        net_term_out,      // Close pulse.
	input wire logic        net_flush_out,     // Drain pulse.
	input wire logic [15:0] net_port_out       // Destination port.
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	// A response stands until it is taken.
	property p_bhold;
		s_axi_bvalid_out && !s_axi_bready_in |=>
			s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold;
		s_axi_rvalid_out && !s_axi_rready_in |=>
			s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_rhold: assert property (p_rhold) else $error("rvalid dropped");
	property p_bnext;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
			&& s_axi_wready_out |=> ##1 s_axi_bvalid_out;
	endproperty
	a_bnext: assert property (p_bnext) else $error("bvalid late");
	property p_blk;
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
	endproperty
	a_blk: assert property (p_blk) else $error("ready while pending");
	property p_setup1;
		net_setup_out |=> !net_setup_out;
	endproperty
	a_setup1: assert property (p_setup1) else $error("setup too long");
	property p_tcp;
		net_setup_out |-> !net_udp_out;
	endproperty
	a_tcp: assert property (p_tcp) else $error("setup on UDP");
	property p_port;
		net_port_out != 16'h0000;
	endproperty
	a_port: assert property (p_port) else $error("port zero");
	property p_term1;
		net_term_out |=> !net_term_out;
	endproperty
	a_term1: assert property (p_term1) else $error("term too long");
	property p_drain;
		net_flush_out |=> !net_term_out;
	endproperty
	a_drain: assert property (p_drain) else $error("no drain");
	c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_setup: cover property (net_setup_out);
	c_flush: cover property (net_flush_out ##[1:20] net_term_out);
endmodule // deh_cmd_chk

bind deh_cmd_handler deh_cmd_chk deh_cmd_chk_i (.*);

// ==== deh_net_model.sv ====
`timescale 1ns/1ps
// Network side: answers a setup after five cycles and drains slowly.
module deh_net_model (
	input  wire logic        mclk_in,        // Clock.
	input  wire logic [1:0]  mode_in,        // 0 silent,1 ok,2 refuse,3 reject.
	input  wire logic        setup_in,       // Setup pulse.
	input  wire logic        flush_in,       // Drain pulse.
	output logic             accept_out = 0, // Accept pulse.
	output logic             refuse_out = 0, // Refuse pulse.
	output logic             reject_out = 0, // Reject pulse.
	output logic [15:0]      reason_out = 16'h0F0F, // Reason code.
	output wire logic        pend_empty_out  // Pending data gone.
);
	logic [3:0] cnt_q = 4'h0; // Cycles to the answer.
	logic [3:0] drn_q = 4'h0; // Cycles of draining left.
	// Data is still pending in the cycle of the flush request itself.
	assign pend_empty_out = drn_q == 4'h0 && !flush_in;
	// The reason toggles unless it qualifies a reject.
	always @(posedge mclk_in)
	begin
		accept_out <= cnt_q == 4'h1 && mode_in == 2'h1;
		refuse_out <= cnt_q == 4'h1 && mode_in == 2'h2;
		reject_out <= cnt_q == 4'h1 && mode_in == 2'h3;
		reason_out <= (cnt_q == 4'h1 && mode_in == 2'h3) ? 16'h3C5A
			: ~reason_out;
		cnt_q <= setup_in ? 4'h5 : cnt_q - (cnt_q != 4'h0);
		drn_q <= flush_in ? 4'h8 : drn_q - (drn_q != 4'h0);
	end
endmodule // deh_net_model

// ==== deh_cmd_handler_bench.sv ====
`timescale 1ns/1ps
`include "deh_consts.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module deh_cmd_handler_bench;
	logic mclk_in = 0, resetn_in = 0, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
	logic s_axi_bready_in = 0, s_axi_arvalid_in = 0, s_axi_rready_in = 0;
	logic [7:0] s_axi_awaddr_in = 0, s_axi_araddr_in = 0, hw;
	logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out, net_ip_out, rv;
	logic [3:0] s_axi_wstrb_in = 4'hF, he;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic s_axi_arready_out, s_axi_rvalid_out, net_accept_in, net_refuse_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp, mode = 0;
	logic dtr_in = 1, host_input_in = 0, registered_in = 1, link_lost_in = 0;
	logic pin_required_in = 0, net_remote_hup_in = 0, tx_attempt_in = 0;
	logic net_reject_in, pend_empty_in, net_setup_out, net_udp_out;
	logic [15:0] net_reason_in, net_port_out;
	logic net_flush_out, net_discard_out, net_term_out, net_dereg_out;
	logic online_out, echo_cmd_out, echo_online_out;
	int bad_count = 0, n_compared = 0, i, f0, d0, t0, r0;
	int n_fl = 0, n_ds = 0, n_tm = 0, n_dr = 0;
	logic [31:0] cfg_t[13] = '{32'h1401, 32'h1401, 32'h1400, 32'h1401,
		32'h0001, 32'h0000, 32'h1401, 32'h1400, 32'h1401, 32'h1401,
		32'h1401, 32'h1401, 32'h1401};
	logic [31:0] ctl_t[13] = '{32'h0001, 32'h0101, 32'h0101, 32'h0101,
		32'h0101, 32'h0101, 32'h0001, 32'h0001, 32'h0001, 32'h5501,
		32'h8201, 32'h4E01, 32'h0101};
	// Mode, registered, PIN pending, expected result.
	logic [7:0] msc_t[13] = '{8'h61, 8'hA7, 8'hA3, 8'hE4, 8'h28, 8'h23,
		8'h46, 8'h43, 8'h7A, 8'h64, 8'h60, 8'h61, 8'h61};
	logic [7:0] hng_t[13] = '{8'h14, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h24, 8'h34, 8'h04};
	deh_cmd_handler #(.TICK_CYCLES(10)) deh_cmd_handler_i (.*);
	deh_net_model deh_net_model_i (.mclk_in, .mode_in(mode),
		.setup_in(net_setup_out), .flush_in(net_flush_out),
		.accept_out(net_accept_in), .refuse_out(net_refuse_in),
		.reject_out(net_reject_in), .reason_out(net_reason_in),
		.pend_empty_out(pend_empty_in));
	always #12.5 mclk_in = ~mclk_in;
	// Counts the flush, discard, close and deregister pulses towards the network.
	always @(posedge mclk_in)
	begin
		n_fl += net_flush_out;
		n_ds += net_discard_out;
		n_tm += net_term_out;
		n_dr += net_dereg_out;
	end
	task wrap_up;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] d, output [1:0] r);
		int n;
		@(posedge mclk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_awvalid_in <= 1;
		s_axi_wvalid_in <= 1;
		s_axi_bready_in <= 1;
		for (n = 0; n < 200 && !s_axi_bvalid_out; n++)
		begin
			@(posedge mclk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 0;
		end
		r = s_axi_bresp_out;
		s_axi_bready_in <= 0;
		if (n == 200) begin bad_count++; wrap_up; end
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		int n;
		@(posedge mclk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1;
		s_axi_rready_in <= 1;
		for (n = 0; n < 200 && !s_axi_rvalid_out; n++)
		begin
			@(posedge mclk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 0;
		end
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		s_axi_rready_in <= 0;
		if (n == 200) begin bad_count++; wrap_up; end
	endtask
	// Polls the status word until a result is flagged.
	task res(input [3:0] e);
		int n;
		for (n = 0; n < 400; n++)
		begin
			rd(`DEH_A_STAT, rv, rsp);
			if (rv[4]) break;
		end
		if (n == 400) begin bad_count++; wrap_up; end
		`CHK(rv[3:0], e)
	endtask
	task cmd(input [31:0] w, input [3:0] e);
		wr(`DEH_A_CTRL, w, rsp);
		res(e);
	endtask
	initial
	begin
		repeat (4) @(posedge mclk_in);
		resetn_in <= 1;
		rd(`DEH_A_CFG, rv, rsp);
		`CHK(rv, 32'h00001401)
		`CHK({echo_cmd_out, echo_online_out, net_port_out}, 18'h20017)
		rd(8'h20, rv, rsp);
		`CHK(rsp, 2'h2)
		wr(8'h30, 32'h0, rsp);
		`CHK(rsp, 2'h2)
		cmd(32'h02, `DEH_RC_OK);
		`CHK(echo_cmd_out, 1'b0)
		cmd(32'h52, `DEH_RC_ERR);
		`CHK(echo_cmd_out, 1'b0)
		cmd(32'h12, `DEH_RC_OK);
		`CHK(echo_cmd_out, 1'b1)
		cmd(32'h03, `DEH_RC_OK);
		`CHK(echo_online_out, 1'b1)
		cmd(32'h13, `DEH_RC_OK);
		`CHK(echo_online_out, 1'b0)
		cmd(32'h44, `DEH_RC_ERR);
		wr(8'h64, 32'h0A0B0C0D, rsp);
		for (i = 0; i < 13; i++)
		begin
			mode <= msc_t[i][7:6];
			registered_in <= msc_t[i][5];
			pin_required_in <= msc_t[i][4];
			wr(`DEH_A_CFG, cfg_t[i], rsp);
			cmd(ctl_t[i], msc_t[i][3:0]);
			if (i == 0) `CHK(net_port_out, 16'h0017)
			if (i == 3) rd(`DEH_A_REJ, rv, rsp);
			if (i == 3) `CHK(rv[15:0], 16'h3C5A)
			if (i == 10) `CHK({online_out, net_udp_out}, 2'b01)
			if (i == 11) `CHK(net_ip_out, 32'h0A0B0C0D)
			hw = hng_t[i];
			if (hw == 8'hFF) continue;
			{f0, d0, t0, r0} = {n_fl, n_ds, n_tm, n_dr};
			cmd({24'h0, hw}, `DEH_RC_OK);
			he = hw == 8'h04 ? 4'hA : hw == 8'h14 ? 4'h0 : hw == 8'h24 ? 4'h6 : 4'h7;
			`CHK({n_fl != f0, n_ds != d0, n_tm != t0, n_dr != r0}, he)
			if (i != 0) continue;
			wr(`DEH_A_CTRL, 32'h04, rsp);
			cmd(32'h14, `DEH_RC_OK);
			`CHK(n_tm, t0)
			`CHK(online_out, 1'b1)
			wr(`DEH_A_STAT, 32'h0, rsp);
			net_remote_hup_in <= 1;
			@(posedge mclk_in);
			net_remote_hup_in <= 0;
			res(`DEH_RC_NOCAR);
		end
		wr(`DEH_A_CFG, 32'h1403, rsp);
		wr(`DEH_A_CTRL, 32'h01, rsp);
		host_input_in <= 1;
		@(posedge mclk_in);
		host_input_in <= 0;
		res(`DEH_RC_NOCAR);
		cmd(32'h01, `DEH_RC_CONN);
		wr(`DEH_A_STAT, 32'h0, rsp);
		dtr_in <= 0;
		res(`DEH_RC_NOCAR);
		`CHK(online_out, 1'b0)
		wrap_up;
	end
endmodule // deh_cmd_handler_bench
